// *** logic/brw_pkg.sv ***
/*
 * Package for the block RAM safe-access wrapper: register offsets, field
 * layouts, reset values, mode encodings and the carrier structs.
 * Assumes a single clk_sys domain and the plain register port.
 */
package brw_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int DEPTH = 256;
	localparam int REG_AW = 4;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [REG_AW-1:0] OFS_CTRL = 4'h0;
	localparam logic [REG_AW-1:0] OFS_STAT = 4'h4;
	localparam logic [REG_AW-1:0] OFS_DBG_ADDR = 4'h8;
	localparam logic [REG_AW-1:0] OFS_DBG_DATA = 4'hc;

	// ---------------------------------------------------------------
	// Control fields
	// ---------------------------------------------------------------
	localparam int CTRL_WRITE_MODE_SELECT_LSB = 0;
	localparam int CTRL_ECC_EN = 2;
	localparam int CTRL_ECC_PIPE = 3;
	localparam int CTRL_SET_MIT = 4;
	localparam int CTRL_DBG_REQ = 5;
	localparam int CTRL_DBG_WR = 6;
	localparam int CTRL_DBG_GO = 7;

	localparam logic [1:0] WRITE_MODE_SELECT_SIMPLE = 2'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] HOLD_CYCLES = 2'h1;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} brw_req_s;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] rdata;
	} brw_rsp_s;

	typedef enum logic [1:0] {
		OWN_USER,
		OWN_DRAIN,
		OWN_DEBUG
	} brw_own_e;

endpackage : brw_pkg

// *** logic/brw_top.sv ***
/*
 * Safe-access wrapper around a single-port view of a large block RAM.
 * Holds the memory array, the collision serializer, the block-select
 * hold for pipelined ECC reads, and the user/debug hand-over.
 * Assumes user logic and software run on clk_sys; rst is asynchronous.
 */
`timescale 1ns/1ps
// Summary of operation
// - Only the simple write mode exists; write mode select is forced to 00.
// - Same-address read and write at once is undefined inside the RAM.
// - The RAM itself neither prevents nor flags collisions.
// - Non-pipelined ECC with mitigation off may give wrong data and flags.
// - Changing owner with live user writes may cause a spurious write.
// - Dropping block select after a pipelined ECC read clears the latch early.
// - Early release yields zero data and false error flags.
module brw_top
	import brw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire brw_req_s user_req,
	input wire logic user_blk_sel,
	output brw_rsp_s user_rsp,
	output logic user_stall,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic port_block_select,
	output logic [1:0] write_mode_select,
	output logic cfg_error,
	output logic ecc_err_flag
);

	typedef struct packed {
		logic [7:0] ctrl;
		logic [ADDR_W-1:0] dbg_addr;
		logic [DATA_W-1:0] dbg_data;
		brw_own_e own;
		logic pend_wr;
		logic [ADDR_W-1:0] pend_addr;
		logic [DATA_W-1:0] pend_data;
		logic [1:0] hold;
		logic rd_done;
		logic rd_late;
		logic coll_seen;
		logic blocked_wr;
		brw_rsp_s rsp;
		logic [31:0] rdata;
		logic blk;
		logic cfg_err;
		logic ecc_err;
		logic stall;
	} brw_state_s;

	brw_state_s s_q;
	brw_state_s s_d;
	logic [DATA_W-1:0] mem [DEPTH];
	logic mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;
	logic [ADDR_W-1:0] mem_raddr;
	logic mem_re;
	logic [DATA_W-1:0] mem_rdata;
	logic user_ok;
	logic collide;
	logic dbg_busy;
	logic ecc_hit;

	// ---------------------------------------------------------------
	// Memory array
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
		if (mem_re) begin
			mem_rdata <= mem[mem_raddr];
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		mem_we = 1'b0;
		mem_re = 1'b0;
		mem_waddr = user_req.addr;
		mem_wdata = user_req.wdata;
		mem_raddr = user_req.addr;
		dbg_busy = (s_q.own != OWN_USER);
		user_ok = !dbg_busy && user_blk_sel;
		collide = user_ok && user_req.wr && user_req.rd;
		s_d.rsp.valid = 1'b0;
		s_d.rd_done = 1'b0;
		s_d.rd_late = s_q.rd_done;

		// Forced constant: the hardware has no other write mode
		s_d.ctrl[CTRL_WRITE_MODE_SELECT_LSB +: 2] = WRITE_MODE_SELECT_SIMPLE;

		// A stored collision write drains first, taking the port for one cycle
		if (s_q.pend_wr) begin
			mem_we = 1'b1;
			mem_waddr = s_q.pend_addr;
			mem_wdata = s_q.pend_data;
			s_d.pend_wr = 1'b0;
		end

		if (user_ok && !s_q.pend_wr) begin
			if (collide) begin
				// Read now, write next cycle, so the array never sees both
				mem_re = 1'b1;
				s_d.pend_wr = 1'b1;
				s_d.pend_addr = user_req.addr;
				s_d.pend_data = user_req.wdata;
				s_d.coll_seen = 1'b1;
				s_d.rd_done = 1'b1;
			end else if (user_req.wr) begin
				mem_we = 1'b1;
			end else if (user_req.rd) begin
				mem_re = 1'b1;
				s_d.rd_done = 1'b1;
			end
		end

		if (s_q.rd_done) begin
			s_d.rsp.valid = 1'b1;
			s_d.rsp.rdata = mem_rdata;
		end

		// Keep select high one extra cycle after a pipelined ECC read
		if (s_d.rd_done && s_q.ctrl[CTRL_ECC_EN] && s_q.ctrl[CTRL_ECC_PIPE]) begin
			s_d.hold = HOLD_CYCLES;
		end else if (s_q.hold != 2'h0) begin
			s_d.hold = s_q.hold - 2'h1;
		end
		s_d.blk = user_ok || s_q.pend_wr || (s_q.hold != 2'h0) || (s_q.own == OWN_DEBUG && s_q.ctrl[CTRL_DBG_GO]);

		// Select gone in the cycle after a pipelined ECC read: zero data and flags would follow
		s_d.ecc_err = s_q.ecc_err;
		ecc_hit = s_q.rd_late && s_q.ctrl[CTRL_ECC_EN] && s_q.ctrl[CTRL_ECC_PIPE] && !s_q.blk;
		if (ecc_hit) begin
			s_d.ecc_err = 1'b1;
		end

		// Unsafe ECC configuration reported, mitigation must be set
		s_d.cfg_err = s_q.ctrl[CTRL_ECC_EN] && !s_q.ctrl[CTRL_ECC_PIPE] && !s_q.ctrl[CTRL_SET_MIT];

		// User write attempted while ownership is draining to debug or debug owns the RAM
		if (dbg_busy && user_req.wr) begin
			s_d.blocked_wr = 1'b1;
		end

		// Ownership hand-over: drain until select and the write strobe are quiet
		case (s_q.own)
			OWN_USER: begin
				if (s_q.ctrl[CTRL_DBG_REQ]) begin
					s_d.own = OWN_DRAIN;
				end
			end
			OWN_DRAIN: begin
				if (!s_q.pend_wr && s_q.hold == 2'h0 && !user_req.wr && !user_blk_sel) begin
					s_d.own = OWN_DEBUG;
				end else if (!s_q.ctrl[CTRL_DBG_REQ]) begin
					s_d.own = OWN_USER;
				end
			end
			OWN_DEBUG: begin
				if (!s_q.ctrl[CTRL_DBG_REQ]) begin
					s_d.own = OWN_USER;
				end
			end
			default: begin
				s_d.own = OWN_USER;
			end
		endcase

		// Stall registered from the next state so the pin comes from a flop
		s_d.stall = s_d.pend_wr || (s_d.own != OWN_USER);

		// Debug command only runs once ownership is debug
		if (s_q.own == OWN_DEBUG && s_q.ctrl[CTRL_DBG_GO]) begin
			s_d.ctrl[CTRL_DBG_GO] = 1'b0;
			mem_waddr = s_q.dbg_addr;
			mem_raddr = s_q.dbg_addr;
			mem_wdata = s_q.dbg_data;
			if (s_q.ctrl[CTRL_DBG_WR]) begin
				mem_we = 1'b1;
			end else begin
				mem_re = 1'b1;
			end
		end
		if (s_q.own == OWN_DEBUG && s_q.blk && !s_q.ctrl[CTRL_DBG_WR] && !s_q.pend_wr) begin
			s_d.dbg_data = mem_rdata;
		end

		// Register port
		s_d.rdata = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					s_d.ctrl[7:2] = reg_wdata[7:2];
				end
				OFS_STAT: begin
					// Write one to clear; a new event in the same cycle wins
					if (reg_wdata[0] && !collide) begin
						s_d.coll_seen = 1'b0;
					end
					if (reg_wdata[1] && !(dbg_busy && user_req.wr)) begin
						s_d.blocked_wr = 1'b0;
					end
					if (reg_wdata[2] && !ecc_hit) begin
						s_d.ecc_err = 1'b0;
					end
				end
				OFS_DBG_ADDR: begin
					s_d.dbg_addr = reg_wdata[ADDR_W-1:0];
				end
				OFS_DBG_DATA: begin
					s_d.dbg_data = reg_wdata[DATA_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL: s_d.rdata = {24'h00_0000, s_q.ctrl};
				OFS_STAT: s_d.rdata = {26'h00_0000, s_q.own, s_q.cfg_err, s_q.ecc_err, s_q.blocked_wr, s_q.coll_seen};
				OFS_DBG_ADDR: s_d.rdata = {{(32-ADDR_W){1'b0}}, s_q.dbg_addr};
				OFS_DBG_DATA: s_d.rdata = {{(32-DATA_W){1'b0}}, s_q.dbg_data};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign user_rsp = s_q.rsp;
	assign user_stall = s_q.stall;
	assign reg_rdata = s_q.rdata;
	assign port_block_select = s_q.blk;
	assign write_mode_select = s_q.ctrl[CTRL_WRITE_MODE_SELECT_LSB +: 2];
	assign cfg_error = s_q.cfg_err;
	assign ecc_err_flag = s_q.ecc_err;

endmodule : brw_top

// *** verification/brw_assertions.sv ***
/* Port checker for brw_top.
   Bound to every brw_top; sees its ports only. */
`timescale 1ns/1ps
module brw_assertions
	import brw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire brw_req_s user_req,
	input wire logic user_blk_sel,
	input wire brw_rsp_s user_rsp,
	input wire logic user_stall,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic port_block_select,
	input wire logic [1:0] write_mode_select,
	input wire logic cfg_error,
	input wire logic ecc_err_flag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic rd_t;
	logic ctl_w;
	logic cfg_x;
	logic pipe_q;
	assign rd_t = user_req.rd && user_blk_sel && !user_stall;
	assign ctl_w = reg_wr && reg_addr == OFS_CTRL;
	assign cfg_x = reg_wdata[CTRL_ECC_EN] && !reg_wdata[CTRL_ECC_PIPE] && !reg_wdata[CTRL_SET_MIT];
	// Mode shadow, so select hold is only demanded in pipelined ECC
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			pipe_q <= 1'b0;
		else if (ctl_w)
			pipe_q <= reg_wdata[CTRL_ECC_EN] && reg_wdata[CTRL_ECC_PIPE];
	end
	a_mode_simple: assert property (write_mode_select == WRITE_MODE_SELECT_SIMPLE)
		else $error("write mode not simple");
	a_coll_serial: assert property (rd_t && user_req.wr |=> user_stall ##1 !user_stall)
		else $error("collision not serialized");
	a_read_answer: assert property (rd_t |-> ##2 user_rsp.valid)
		else $error("read answer missing");
	a_rsp_cause: assert property (user_rsp.valid |-> $past(rd_t, 2))
		else $error("answer without read");
	a_sel_hold: assert property (rd_t && pipe_q |=> port_block_select [*2])
		else $error("select dropped after read");
	a_no_false_err: assert property (!ecc_err_flag)
		else $error("false ecc error");
	a_cfg_check: assert property (ctl_w ##1 !ctl_w ##1 !ctl_w |-> cfg_error == $past(cfg_x, 2))
		else $error("cfg error wrong");
	a_dbg_fence: assert property (ctl_w && reg_wdata[CTRL_DBG_REQ] && !user_blk_sel |-> ##[1:4] user_stall)
		else $error("user not fenced");
	c_coll: cover property (rd_t && user_req.wr);
	c_pipe_rd: cover property (rd_t && pipe_q);
	c_dbg_go: cover property (ctl_w && reg_wdata[CTRL_DBG_GO]);
endmodule : brw_assertions

bind brw_top brw_assertions i_chk (.*);

// *** verification/brw_user_model.sv ***
/* Fabric user logic driving the RAM port.
   Takes one command from the bench; holds it while stalled. */
`timescale 1ns/1ps
module brw_user_model
	import brw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire brw_req_s cmd,
	input wire logic user_stall,
	output brw_req_s user_req,
	output logic user_blk_sel
);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			user_req <= '0;
			user_blk_sel <= 1'b0;
		end else if (!(user_stall && user_blk_sel)) begin
			user_blk_sel <= cmd.rd | cmd.wr;
			if (cmd.rd | cmd.wr) begin
				user_req <= cmd;
			end else begin
				// Idle lines carry junk, never the last value
				user_req <= '{1'b0, 1'b0, ~user_req.addr, ~user_req.wdata};
			end
		end
	end
endmodule : brw_user_model

// *** verification/block_ram_safe_access_wrapper_bench.sv ***
/* Self-checking bench for brw_top with a memory model.
   Needs brw_user_model and the bound checker. */
`timescale 1ns/1ps
module block_ram_safe_access_wrapper_bench;
	import brw_pkg::*;
	logic clk_sys = 0;
	logic rst = 1;
	brw_req_s cmd = '0;
	brw_req_s user_req;
	brw_rsp_s user_rsp;
	logic user_blk_sel, user_stall, port_block_select, cfg_error, ecc_err_flag;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [REG_AW-1:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic [31:0] reg_rdata, d;
	logic [1:0] write_mode_select;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int mem [DEPTH];
	int exp_q [$];

	brw_user_model i_user (.*);
	brw_top i_dut (.*);

	initial forever #5 clk_sys = ~clk_sys;

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task finish_test;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	task rw(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 0;
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask : rw

	// Spaced so a held command never meets a collision stall
	task uop(input logic r, input logic w, input int a, input int v);
		@(posedge clk_sys);
		cmd <= '{w, r, a[7:0], v[15:0]};
		@(posedge clk_sys);
		cmd <= '0;
		repeat (3) @(posedge clk_sys);
	endtask : uop

	// ----
	// Reference: read first, then write
	// ----
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			finish_test();
		end
		if (!rst && user_blk_sel && !user_stall) begin
			if (user_req.rd)
				exp_q.push_back(mem[user_req.addr]);
			if (user_req.wr)
				mem[user_req.addr] = user_req.wdata;
		end
		if (!rst && user_rsp.valid)
			chk("rdata", user_rsp.rdata, exp_q.size() ? exp_q.pop_front() : -1);
	end

	initial begin
		int i;
		void'($urandom(1771));
		repeat (16) @(posedge clk_sys);
		rst <= 0;
		rw(1, OFS_CTRL, 32'h0000_0003);
		rw(0, OFS_CTRL, 0);
		chk("mode", d[1:0], WRITE_MODE_SELECT_SIMPLE);
		chk("wm_pin", write_mode_select, WRITE_MODE_SELECT_SIMPLE);
		rw(0, 4'h2, 0);
		chk("unmapped", d, 0);
		for (i = 0; i < 8; i++) begin
			rw(1, OFS_CTRL, i << 2);
			repeat (2) @(posedge clk_sys);
			chk("cfg", cfg_error, i == 1);
		end
		rw(1, OFS_CTRL, 32'h0000_000c);
		for (i = 0; i < 16; i++)
			uop(0, 1, i, $urandom);
		uop(1, 1, 5, 16'hbeef);
		rw(0, OFS_STAT, 0);
		chk("coll_bit", d[0], 1);
		rw(1, OFS_STAT, 32'h0000_0001);
		rw(0, OFS_STAT, 0);
		chk("coll_clr", d[0], 0);
		uop(1, 0, 5, 0);
		for (i = 0; i < 16; i++)
			uop(1, 0, $urandom % 16, 0);
		chk("ecc_flag", ecc_err_flag, 0);
		rw(1, OFS_CTRL, 32'h0000_0020);
		repeat (4) @(posedge clk_sys);
		rw(0, OFS_STAT, 0);
		chk("owner", d[5:4], 2);
		uop(0, 1, 7, 16'h1234);
		rw(0, OFS_STAT, 0);
		chk("blocked", d[1], 1);
		rw(1, OFS_DBG_ADDR, 5);
		rw(1, OFS_CTRL, 32'h0000_00a0);
		repeat (4) @(posedge clk_sys);
		rw(0, OFS_DBG_DATA, 0);
		chk("dbg_rd", d[15:0], mem[5]);
		rw(1, OFS_DBG_DATA, 32'h0000_5a5a);
		rw(1, OFS_CTRL, 32'h0000_00e0);
		mem[5] = 32'h0000_5a5a;
		repeat (4) @(posedge clk_sys);
		rw(1, OFS_CTRL, 0);
		repeat (4) @(posedge clk_sys);
		uop(1, 0, 5, 0);
		repeat (2) @(posedge clk_sys);
		chk("pending", exp_q.size(), 0);
		finish_test();
	end
endmodule : block_ram_safe_access_wrapper_bench
